// ==== src/tbt_transceiver.sv ====
// Top of the 18-bit registered bidirectional bus transceiver.
// Assumes all pins are asynchronous to clk; a testbench resolves pin levels from enables.

`timescale 1ns/1ps

module tbt_transceiver
(
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          ce,
  input  wire logic                          a_to_b_capture_clk,
  input  wire logic                          b_to_a_capture_clk,
  input  wire logic                          a_to_b_drive_en_n,
  input  wire logic                          b_to_a_drive_en_n,
  input  wire logic                          half1_a_to_b_capture_en_n,
  input  wire logic                          half2_a_to_b_capture_en_n,
  input  wire logic                          half1_b_to_a_capture_en_n,
  input  wire logic                          half2_b_to_a_capture_en_n,
  input  wire logic [tbt_pkg::BUS_W-1:0]     a_in,
  output logic      [tbt_pkg::BUS_W-1:0]     a_out,
  output logic      [tbt_pkg::BUS_W-1:0]     a_oe,
  input  wire logic [tbt_pkg::BUS_W-1:0]     b_in,
  output logic      [tbt_pkg::BUS_W-1:0]     b_out,
  output logic      [tbt_pkg::BUS_W-1:0]     b_oe
);

  // ---------------------------------------------------------------
  // Edge detection helper.
  // ---------------------------------------------------------------
  function automatic logic tbt_rise(input logic cur, input logic prev);
    tbt_rise = cur & ~prev;
  endfunction : tbt_rise

  // ---------------------------------------------------------------
  // Synchroniser stages for pin inputs.
  // ---------------------------------------------------------------
  logic                           ab_clk_s1_reg;
  logic                           ab_clk_s2_reg;
  logic                           ab_clk_prev_reg;
  logic                           ba_clk_s1_reg;
  logic                           ba_clk_s2_reg;
  logic                           ba_clk_prev_reg;
  logic                           ab_drv_s1_reg;
  logic                           ab_drv_s2_reg;
  logic                           ba_drv_s1_reg;
  logic                           ba_drv_s2_reg;
  logic [3:0]                     cen_s1_reg;
  logic [3:0]                     cen_s2_reg;
  logic [tbt_pkg::BUS_W-1:0]      a_s1_reg;
  logic [tbt_pkg::BUS_W-1:0]      a_s2_reg;
  logic [tbt_pkg::BUS_W-1:0]      b_s1_reg;
  logic [tbt_pkg::BUS_W-1:0]      b_s2_reg;

  // ---------------------------------------------------------------
  // Capture pulses and stored data.
  // ---------------------------------------------------------------
  logic                           ab_pulse;
  logic                           ba_pulse;
  logic [tbt_pkg::HALF_W-1:0]     ab_h1_reg;
  logic [tbt_pkg::HALF_W-1:0]     ab_h2_reg;
  logic [tbt_pkg::HALF_W-1:0]     ba_h1_reg;
  logic [tbt_pkg::HALF_W-1:0]     ba_h2_reg;
  logic                           b_drive_reg;
  logic                           a_drive_reg;

  // ---------------------------------------------------------------
  // Capture clock synchronisers.
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ab_clk_s1_reg   <= tbt_pkg::SYNC_RESET_VAL;
      ab_clk_s2_reg   <= tbt_pkg::SYNC_RESET_VAL;
      ab_clk_prev_reg <= tbt_pkg::SYNC_RESET_VAL;
      ba_clk_s1_reg   <= tbt_pkg::SYNC_RESET_VAL;
      ba_clk_s2_reg   <= tbt_pkg::SYNC_RESET_VAL;
      ba_clk_prev_reg <= tbt_pkg::SYNC_RESET_VAL;
    end
    else if (ce)
    begin
      ab_clk_s1_reg   <= a_to_b_capture_clk;
      ab_clk_s2_reg   <= ab_clk_s1_reg;
      ab_clk_prev_reg <= ab_clk_s2_reg;
      ba_clk_s1_reg   <= b_to_a_capture_clk;
      ba_clk_s2_reg   <= ba_clk_s1_reg;
      ba_clk_prev_reg <= ba_clk_s2_reg;
    end
  end

  // ---------------------------------------------------------------
  // Drive enable synchronisers.
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ab_drv_s1_reg <= tbt_pkg::DRIVE_OFF_N;
      ab_drv_s2_reg <= tbt_pkg::DRIVE_OFF_N;
      ba_drv_s1_reg <= tbt_pkg::DRIVE_OFF_N;
      ba_drv_s2_reg <= tbt_pkg::DRIVE_OFF_N;
    end
    else if (ce)
    begin
      ab_drv_s1_reg <= a_to_b_drive_en_n;
      ab_drv_s2_reg <= ab_drv_s1_reg;
      ba_drv_s1_reg <= b_to_a_drive_en_n;
      ba_drv_s2_reg <= ba_drv_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Capture enable synchronisers, one per half and direction.
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cen_s1_reg <= 4'hF;
      cen_s2_reg <= 4'hF;
    end
    else if (ce)
    begin
      cen_s1_reg <= {half2_b_to_a_capture_en_n, half1_b_to_a_capture_en_n,
                     half2_a_to_b_capture_en_n, half1_a_to_b_capture_en_n};
      cen_s2_reg <= cen_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Data synchronisers, aligned with the capture clock path.
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      a_s1_reg <= 18'h00000;
      a_s2_reg <= 18'h00000;
      b_s1_reg <= 18'h00000;
      b_s2_reg <= 18'h00000;
    end
    else if (ce)
    begin
      a_s1_reg <= a_in;
      a_s2_reg <= a_s1_reg;
      b_s1_reg <= b_in;
      b_s2_reg <= b_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Rising edges of the capture clocks; a steady level yields none.
  // ---------------------------------------------------------------
  assign ab_pulse = tbt_rise(ab_clk_s2_reg, ab_clk_prev_reg);
  assign ba_pulse = tbt_rise(ba_clk_s2_reg, ba_clk_prev_reg);

  // ---------------------------------------------------------------
  // Storage halves; capture ignores the drive enables.
  // ---------------------------------------------------------------
  tbt_half_store u_ab_half1
  (
    .clk           (clk),
    .resetn        (resetn),
    .ce            (ce),
    .capture_pulse (ab_pulse),
    .capture_en_n  (cen_s2_reg[0]),
    .data_in       (a_s2_reg[tbt_pkg::HALF1_LSB +: tbt_pkg::HALF_W]),
    .data_reg      (ab_h1_reg)
  );

  tbt_half_store u_ab_half2
  (
    .clk           (clk),
    .resetn        (resetn),
    .ce            (ce),
    .capture_pulse (ab_pulse),
    .capture_en_n  (cen_s2_reg[1]),
    .data_in       (a_s2_reg[tbt_pkg::HALF2_LSB +: tbt_pkg::HALF_W]),
    .data_reg      (ab_h2_reg)
  );

  tbt_half_store u_ba_half1
  (
    .clk           (clk),
    .resetn        (resetn),
    .ce            (ce),
    .capture_pulse (ba_pulse),
    .capture_en_n  (cen_s2_reg[2]),
    .data_in       (b_s2_reg[tbt_pkg::HALF1_LSB +: tbt_pkg::HALF_W]),
    .data_reg      (ba_h1_reg)
  );

  tbt_half_store u_ba_half2
  (
    .clk           (clk),
    .resetn        (resetn),
    .ce            (ce),
    .capture_pulse (ba_pulse),
    .capture_en_n  (cen_s2_reg[3]),
    .data_in       (b_s2_reg[tbt_pkg::HALF2_LSB +: tbt_pkg::HALF_W]),
    .data_reg      (ba_h2_reg)
  );

  // ---------------------------------------------------------------
  // Output driver enables.
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      b_drive_reg <= 1'h0;
      a_drive_reg <= 1'h0;
    end
    else if (ce)
    begin
      b_drive_reg <= ~ab_drv_s2_reg;
      a_drive_reg <= ~ba_drv_s2_reg;
    end
  end

  // ---------------------------------------------------------------
  // Pin outputs.
  // ---------------------------------------------------------------
  assign b_out = {ab_h2_reg, ab_h1_reg};
  assign b_oe  = {tbt_pkg::BUS_W{b_drive_reg}};
  assign a_out = {ba_h2_reg, ba_h1_reg};
  assign a_oe  = {tbt_pkg::BUS_W{a_drive_reg}};

endmodule : tbt_transceiver

// ==== src/tbt_pkg.sv ====
// Constants shared by the registered bus transceiver design files.
// Assumes a single 50 MHz system clock; no register bus exists.

package tbt_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int HALF_W   = 9;
  localparam int HALVES   = 2;
  localparam int BUS_W    = HALF_W * HALVES;

  // ---------------------------------------------------------------
  // Half indices within the bus
  // ---------------------------------------------------------------
  localparam int HALF1_LSB = 0;
  localparam int HALF2_LSB = 9;

  // ---------------------------------------------------------------
  // Synchroniser depth and timing
  // ---------------------------------------------------------------
  localparam int SYNC_STAGES   = 2;
  localparam int CLK_PERIOD_NS = 20;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [8:0] HALF_RESET_VAL = 9'h000;
  localparam logic       DRIVE_OFF_N    = 1'h1;
  localparam logic       SYNC_RESET_VAL = 1'h0;

endpackage : tbt_pkg

// ==== src/tbt_half_store.sv ====
// One 9-bit storage half for one transfer direction.
// Assumes capture pulse, enable and data are already in the clk domain.

`timescale 1ns/1ps

module tbt_half_store
(
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic                          ce,
  input  wire logic                          capture_pulse,
  input  wire logic                          capture_en_n,
  input  wire logic [tbt_pkg::HALF_W-1:0]    data_in,
  output logic      [tbt_pkg::HALF_W-1:0]    data_reg
);

  // ---------------------------------------------------------------
  // Storage flip-flops.
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_reg <= tbt_pkg::HALF_RESET_VAL;
    end
    else if (ce && capture_pulse && !capture_en_n)
    begin
      data_reg <= data_in;
    end
  end

endmodule : tbt_half_store

// ==== test/tbt_monitor.sv ====
// Pin-level assertions for the registered bus transceiver.
// Assumes ce high and pins held steady around each capture edge.
`timescale 1ns/1ps
module tbt_monitor
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        a_to_b_capture_clk,
  input wire logic        b_to_a_capture_clk,
  input wire logic        a_to_b_drive_en_n,
  input wire logic        b_to_a_drive_en_n,
  input wire logic        half1_a_to_b_capture_en_n,
  input wire logic        half2_a_to_b_capture_en_n,
  input wire logic        half1_b_to_a_capture_en_n,
  input wire logic        half2_b_to_a_capture_en_n,
  input wire logic [17:0] a_in,
  input wire logic [17:0] a_out,
  input wire logic [17:0] a_oe,
  input wire logic [17:0] b_in,
  input wire logic [17:0] b_out,
  input wire logic [17:0] b_oe
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || !ce);
  ab_h1_load_a: assert property (
    $rose(a_to_b_capture_clk) && !half1_a_to_b_capture_en_n
    |-> ##4 b_out[8:0] == $past(a_in[8:0], 4)) else $error("half1 A-to-B load wrong");
  ab_h2_load_a: assert property (
    $rose(a_to_b_capture_clk) && !half2_a_to_b_capture_en_n
    |-> ##4 b_out[17:9] == $past(a_in[17:9], 4)) else $error("half2 A-to-B load wrong");
  ba_h1_load_a: assert property (
    $rose(b_to_a_capture_clk) && !half1_b_to_a_capture_en_n
    |-> ##4 a_out[8:0] == $past(b_in[8:0], 4)) else $error("half1 B-to-A load wrong");
  ba_h2_load_a: assert property (
    $rose(b_to_a_capture_clk) && !half2_b_to_a_capture_en_n
    |-> ##4 a_out[17:9] == $past(b_in[17:9], 4)) else $error("half2 B-to-A load wrong");
  b_drive_a: assert property ((!a_to_b_drive_en_n)[*5] |-> &b_oe)
    else $error("B side not driven");
  b_float_a: assert property (a_to_b_drive_en_n[*5] |-> !(|b_oe))
    else $error("B side not floating");
  a_float_a: assert property (b_to_a_drive_en_n[*5] |-> !(|a_oe))
    else $error("A side not floating");
  a_drive_a: assert property ((!b_to_a_drive_en_n)[*5] |-> &a_oe)
    else $error("A side not driven");
  h1_refuse_a: assert property (
    half1_a_to_b_capture_en_n[*5] |-> $stable(b_out[8:0])) else $error("half1 loaded");
  clk_still_a: assert property (
    $stable(a_to_b_capture_clk)[*5] |-> $stable(b_out)) else $error("B changed, no edge");
endmodule : tbt_monitor

bind tbt_transceiver tbt_monitor i_mon
(
  .clk, .resetn, .ce, .a_to_b_capture_clk, .b_to_a_capture_clk, .a_to_b_drive_en_n,
  .b_to_a_drive_en_n, .half1_a_to_b_capture_en_n, .half2_a_to_b_capture_en_n,
  .half1_b_to_a_capture_en_n, .half2_b_to_a_capture_en_n,
  .a_in, .a_out, .a_oe, .b_in, .b_out, .b_oe
);

// ==== test/tbt_bus_partner.sv ====
// Card logic on the A pins and backplane on the B pins.
// Assumes the bench only lets a side drive while the device does not.
`timescale 1ns/1ps
module tbt_bus_partner
(
  input  wire logic [17:0] a_out,
  input  wire logic [17:0] a_oe,
  input  wire logic [17:0] b_out,
  input  wire logic [17:0] b_oe,
  input  wire logic [17:0] card_val,
  input  wire logic        card_oe,
  input  wire logic [17:0] bp_val,
  input  wire logic        bp_oe,
  output logic      [17:0] a_pin,
  output logic      [17:0] b_pin
);
  // Undriven A lines show the inverse of the stored value; undriven B lines are pulled high.
  assign a_pin = (a_oe & a_out) | (~a_oe & ({18{card_oe}} & card_val | {18{~card_oe}} & ~a_out));
  assign b_pin = (b_oe & b_out) | (~b_oe & ({18{bp_oe}} & bp_val | {18{~bp_oe}}));
endmodule : tbt_bus_partner

// ==== test/tbt_transceiver_tb_top.sv ====
// Self-checking bench for the registered bus transceiver.
// Assumes the partner model resolves the pin levels on both sides.
`timescale 1ns/1ps
module tbt_transceiver_tb_top;
  logic        clk, resetn, ce, cka, ckb, dab_n, dba_n;
  logic [3:0]  en_n;
  logic [17:0] card, bp, a_in, a_out, a_oe, b_in, b_out, b_oe, ab_exp, ba_exp, hold;
  int          error_cnt, check_count;

  tbt_transceiver i_dut
  (
    .clk(clk), .resetn(resetn), .ce(ce),
    .a_to_b_capture_clk(cka), .b_to_a_capture_clk(ckb),
    .a_to_b_drive_en_n(dab_n), .b_to_a_drive_en_n(dba_n),
    .half1_a_to_b_capture_en_n(en_n[0]), .half2_a_to_b_capture_en_n(en_n[1]),
    .half1_b_to_a_capture_en_n(en_n[2]), .half2_b_to_a_capture_en_n(en_n[3]),
    .a_in(a_in), .a_out(a_out), .a_oe(a_oe), .b_in(b_in), .b_out(b_out), .b_oe(b_oe)
  );
  tbt_bus_partner i_bus
  (
    .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .card_val(card),
    .card_oe(dba_n), .bp_val(bp), .bp_oe(dab_n), .a_pin(a_in), .b_pin(b_in)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [17:0] load(logic [17:0] old, logic [17:0] pin, logic h1n, logic h2n);
    load = old;
    if (!h1n) load[8:0] = pin[8:0];
    if (!h2n) load[17:9] = pin[17:9];
  endfunction : load

  task automatic check(logic [17:0] seen, logic [17:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask : check

  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic xfer(logic pa, logic pb);
    logic [17:0] ap, bq;
    ap = dba_n ? card : ba_exp;
    bq = dab_n ? bp : ab_exp;
    if (pa) ab_exp = load(ab_exp, ap, en_n[0], en_n[1]);
    if (pb) ba_exp = load(ba_exp, bq, en_n[2], en_n[3]);
    cka = pa;
    ckb = pb;
    step(3);
    cka = 1'b0;
    ckb = 1'b0;
    step(6);
    check(b_out, ab_exp);
    check(a_out, ba_exp);
    check(b_oe, {18{~dab_n}});
    check(a_oe, {18{~dba_n}});
  endtask : xfer

  task finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #200000;
    error_cnt++;
    $display("mismatch at %0t: run did not finish", $time);
    finish_test();
  end

  initial
  begin
    {resetn, cka, ckb, error_cnt, check_count} = '0;
    {ce, dab_n, dba_n, en_n} = 7'h7F;
    {card, bp, ab_exp, ba_exp} = '0;
    void'($urandom(32'h34AF));
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    step(2);
    xfer(1'b0, 1'b0);
    $display("test reset done");
    {dab_n, en_n} = 5'h00;
    card = 18'h3FFFF;
    step(5);
    xfer(1'b1, 1'b1);
    en_n = 4'hE;
    card = 18'h00000;
    step(5);
    xfer(1'b1, 1'b0);
    $display("test half split done");
    {dab_n, dba_n, en_n} = 6'h30;
    card = 18'h2AD55;
    step(5);
    xfer(1'b1, 1'b1);
    dab_n = 1'b0;
    step(5);
    xfer(1'b0, 1'b0);
    $display("test store while floating done");
    cka = 1'b1;
    ab_exp = card;
    step(6);
    repeat (3)
    begin
      card = 18'($urandom);
      step(3);
      check(b_out, ab_exp);
    end
    cka = 1'b0;
    step(6);
    $display("test steady clock done");
    ce = 1'b0;
    hold = b_oe;
    dab_n = 1'b1;
    step(8);
    check(b_oe, hold);
    ce = 1'b1;
    step(6);
    check(b_oe, 18'h00000);
    $display("test freeze done");
    repeat (40)
    begin
      {dab_n, dba_n, en_n} = 6'($urandom);
      card = 18'($urandom);
      bp = 18'($urandom);
      step(5);
      xfer(1'($urandom), 1'($urandom));
    end
    $display("test random done");
    finish_test();
  end
endmodule : tbt_transceiver_tb_top
